// ===== core/serial_dac_input.sv
`timescale 1ns/100ps
module serial_dac_input (
    input  wire logic                              clock_i,
    input  wire logic                              rst_i,
    input  wire logic                              bit_clock_i,
    input  wire logic                              serial_data_i,
    input  wire logic                              word_latch_clock_i,
    input  wire logic                              channel_select_i,
    input  wire logic                              single_dac_mode_select_i,
    input  wire logic                              dac_channel_assign_i,
    output logic signed [serial_dac_pkg::WORD_W-1:0] dac_word_o,
    output logic signed [serial_dac_pkg::WORD_W-1:0] left_out_o,
    output logic signed [serial_dac_pkg::WORD_W-1:0] right_out_o,
    output logic                                   left_parked_o,
    output serial_dac_pkg::amp_mode_t              left_mode_o,
    output serial_dac_pkg::amp_mode_t              right_mode_o
);
    import serial_dac_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [SYNC_W-1:0] bclk_s_r;      // bit clock stages
    logic [SYNC_W-1:0] data_s_r;      // serial data stages
    logic [SYNC_W-1:0] wlat_s_r;      // word latch clock stages
    logic [SYNC_W-1:0] csel_s_r;      // channel select stages
    logic [SYNC_W-1:0] sdm_s_r;       // single mode stages
    logic [SYNC_W-1:0] asg_s_r;       // channel assign stages
    logic              bclk_lvl_r;    // accepted bit clock level
    logic              bclk_lvl_nxt;  // next accepted level
    logic              rise;          // one-cycle rising edge pulse

    // shift each pin through three flops
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_s_r <= '0;
            data_s_r <= '0;
            wlat_s_r <= '0;
            csel_s_r <= '0;
            sdm_s_r  <= '0;
            asg_s_r  <= '0;
        end else begin
            bclk_s_r <= {bclk_s_r[SYNC_W-2:0], bit_clock_i};
            data_s_r <= {data_s_r[SYNC_W-2:0], serial_data_i};
            wlat_s_r <= {wlat_s_r[SYNC_W-2:0], word_latch_clock_i};
            csel_s_r <= {csel_s_r[SYNC_W-2:0], channel_select_i};
            sdm_s_r  <= {sdm_s_r[SYNC_W-2:0], single_dac_mode_select_i};
            asg_s_r  <= {asg_s_r[SYNC_W-2:0], dac_channel_assign_i};
        end
    end

    // bit clock level changes once stages two and three agree
    always_comb begin
        bclk_lvl_nxt = bclk_lvl_r;
        rise         = 1'b0;
        if (bclk_s_r[SYNC_MID] == bclk_s_r[SYNC_MSB]) begin
            bclk_lvl_nxt = bclk_s_r[SYNC_MSB];
            rise = bclk_s_r[SYNC_MSB] && !bclk_lvl_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // serial register, latch and steering
    logic [WORD_W-1:0] shift_r;      // serial input register
    logic [WORD_W-1:0] shift_nxt;
    logic [WORD_W-1:0] dac_r;        // parallel dac register
    logic [WORD_W-1:0] dac_nxt;
    logic              wl_prev_r;    // latch level seen at last edge
    logic              wl_prev_nxt;
    logic [WORD_W-1:0] left_r;       // left amplifier value
    logic [WORD_W-1:0] left_nxt;
    logic [WORD_W-1:0] right_r;      // right amplifier value
    logic [WORD_W-1:0] right_nxt;
    logic              wl;           // sampled word latch level
    logic              cs;           // sampled channel select
    logic              sdm;          // sampled single mode
    logic              asg;          // sampled channel assign
    logic              accept;       // word accepted this phase
    logic              left_int;     // left integrates
    logic              right_int;    // right integrates

    assign wl  = wlat_s_r[SYNC_MSB];
    assign cs  = csel_s_r[SYNC_MSB];
    assign sdm = sdm_s_r[SYNC_MSB];
    assign asg = asg_s_r[SYNC_MSB];

    // channel decode from the truth table
    always_comb begin
        if (sdm) begin
            accept    = asg ? !cs : cs;
            left_int  = 1'b0;
            right_int = cs;
        end else begin
            accept    = 1'b1;
            left_int  = wl && !cs;
            right_int = wl && cs;
        end
    end

    // all state moves only on an accepted bit clock rise
    always_comb begin
        shift_nxt   = shift_r;
        dac_nxt     = dac_r;
        wl_prev_nxt = wl_prev_r;
        left_nxt    = left_r;
        right_nxt   = right_r;
        if (rise) begin
            // msb first, older bits fall off the top
            shift_nxt   = {shift_r[WORD_W-2:0], data_s_r[SYNC_MSB]};
            wl_prev_nxt = wl;
            // transfer on first edge with latch seen low, from the
            // register as it stood before this edge's shift
            if (!wl && wl_prev_r) begin
                if (accept) begin
                    dac_nxt = shift_r;
                end
            end
            if (left_int) begin
                left_nxt = dac_r;
            end
            if (right_int) begin
                right_nxt = dac_r;
            end
        end
    end

    // register serial and output state
    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            bclk_lvl_r <= 1'b0;
            shift_r    <= BIPOLAR_ZERO_CODE;
            dac_r      <= BIPOLAR_ZERO_CODE;
            wl_prev_r  <= 1'b0;
            left_r     <= BIPOLAR_ZERO_CODE;
            right_r    <= BIPOLAR_ZERO_CODE;
        end else begin
            bclk_lvl_r <= bclk_lvl_nxt;
            shift_r    <= shift_nxt;
            dac_r      <= dac_nxt;
            wl_prev_r  <= wl_prev_nxt;
            left_r     <= left_nxt;
            right_r    <= right_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs: signed codes, left parked at common in single mode
    assign dac_word_o    = signed'(dac_r);
    assign right_out_o   = signed'(right_r);
    assign left_out_o    = sdm ? signed'(COMMON_LEVEL_CODE)
                               : signed'(left_r);
    assign left_parked_o = sdm;
    assign left_mode_o   = sdm ? MODE_COMMON
                               : (left_int ? MODE_INTEGRATE : MODE_HOLD);
    assign right_mode_o  = right_int ? MODE_INTEGRATE : MODE_HOLD;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_no_edge_hold: assert property (
        @(posedge clock_i) disable iff (rst_i)
        !rise |=> $stable(dac_r) && $stable(shift_r))
        else $error("dac state moved without bit clock rise");

    a_shift_msb: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise |=> shift_r[WORD_W-1:1] == $past(shift_r[WORD_W-2:0]))
        else $error("shift register lost bit order");

    a_latch_xfer: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && !wl && wl_prev_r && accept |=> dac_r == $past(shift_r))
        else $error("word not transferred after latch fell");

    a_no_xfer_high: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && (wl || !wl_prev_r) |=> $stable(dac_r))
        else $error("transfer without latch falling");

    a_left_parked: assert property (
        @(posedge clock_i) disable iff (rst_i)
        sdm |-> left_out_o == signed'(COMMON_LEVEL_CODE) && left_parked_o)
        else $error("left not parked in single mode");

    a_single_inhibit: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && sdm && (asg == cs) |=> $stable(dac_r))
        else $error("inhibited word was accepted");

    a_dual_steer: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && !sdm && !wl |=> $stable(left_r) && $stable(right_r))
        else $error("output moved while latch clock low");

    a_integrate: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && right_int |=> right_r == $past(dac_r))
        else $error("right integrate did not take dac word");

    // new bit enters at the bottom, so the word arrives msb first
    a_shift_lsb: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise |=> shift_r[0] == $past(data_s_r[SYNC_MSB]))
        else $error("serial bit not shifted in at lsb");

    // the selected channel in single mode must really be taken
    a_single_accept: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && sdm && (asg != cs) && !wl && wl_prev_r
            |=> dac_r == $past(shift_r))
        else $error("selected word not transferred in single mode");

    // left integrates from the dac register while latch high, select low
    a_left_steer: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && !sdm && wl && !cs |=> left_r == $past(dac_r))
        else $error("left integrate did not take dac word");

    // hold phase keeps the right value untouched
    a_right_hold: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && !right_int |=> $stable(right_r))
        else $error("right output moved while holding");

    // left path is disabled in single mode, its value must not move
    a_left_frozen: assert property (
        @(posedge clock_i) disable iff (rst_i)
        rise && sdm |=> $stable(left_r))
        else $error("left value moved in single mode");
endmodule : serial_dac_input

// ===== core/serial_dac_pkg.sv
package serial_dac_pkg;
    localparam int WORD_W = 16;                                  // dac word width
    localparam logic [WORD_W-1:0] FULL_POS_CODE = 16'h7fff;      // +full scale
    localparam logic [WORD_W-1:0] BIPOLAR_ZERO_CODE = 16'h0000;  // zero
    localparam logic [WORD_W-1:0] FULL_NEG_CODE = 16'h8000;      // -full scale
    localparam logic [WORD_W-1:0] COMMON_LEVEL_CODE = 16'h2e5b;  // common
    localparam int SYNC_W = 3;                                   // pin sync depth
    localparam int SYNC_MSB = 2;                                 // last sync stage
    localparam int SYNC_MID = 1;                                 // second stage
    // output amplifier mode of one channel
    typedef enum logic [1:0] {
        MODE_HOLD,
        MODE_INTEGRATE,
        MODE_COMMON
    } amp_mode_t;
endpackage : serial_dac_pkg

// ===== dv/audio_source.sv
`timescale 1ns/100ps
//////////////////////////////////////////////////////////////////////
// serial word source; bit clock stands low between frames
module audio_source (
    input  wire logic        clock_i,
    input  wire logic        go_i,
    input  wire logic        extra_i,
    input  wire logic [15:0] word_i,
    output logic             bit_clock_o,
    output logic             data_o,
    output logic             latch_o,
    output logic             done_o
);
    // lines start idle, then one frame per go; lines move only while
    // the bit clock is low, so one process owns every line
    initial begin
        bit_clock_o = 1'b0;
        data_o = 1'b0;
        latch_o = 1'b0;
        done_o = 1'b1;
        forever begin
            @(posedge clock_i);
            if (go_i) begin
                done_o <= 1'b0;
                for (int i = 0; i < 16 + int'(extra_i); i++) begin
                    data_o <= (i < 16) ? word_i[15-i] : ~word_i[0];
                    latch_o <= (i >= 8) && (i < 16);
                    repeat (20) @(posedge clock_i);
                    bit_clock_o <= 1'b1;
                    repeat (20) @(posedge clock_i);
                    bit_clock_o <= 1'b0;
                end
                data_o <= ~data_o; // released line shows the inverse
                done_o <= 1'b1;
            end
        end
    end
endmodule : audio_source

// ===== dv/dual_channel_serial_dac_input_control_bench.sv
`timescale 1ns/100ps
module dual_channel_serial_dac_input_control_bench;
    import serial_dac_pkg::*;
    logic               clock_i = 1'b0;
    logic               rst_i = 1'b1;
    logic               go = 1'b0, extra = 1'b0, sel = 1'b0;
    logic               mode = 1'b0, chan_assign = 1'b0;
    logic [15:0]        word = 16'h0000;
    logic               bclk, sdata, latch, done, parked;
    logic signed [15:0] dac, lout, rout, pair_dac;
    amp_mode_t          lmode, rmode;
    int                 n_errors = 0;
    int                 checks = 0;
    always #2 clock_i = ~clock_i;
    audio_source src_u (.clock_i(clock_i), .go_i(go), .extra_i(extra),
        .word_i(word), .bit_clock_o(bclk), .data_o(sdata),
        .latch_o(latch), .done_o(done));
    serial_dac_input dut_u (.clock_i(clock_i), .rst_i(rst_i),
        .bit_clock_i(bclk), .serial_data_i(sdata),
        .word_latch_clock_i(latch), .channel_select_i(sel),
        .single_dac_mode_select_i(mode),
        .dac_channel_assign_i(chan_assign), .dac_word_o(dac),
        .left_out_o(lout), .right_out_o(rout), .left_parked_o(parked),
        .left_mode_o(lmode), .right_mode_o(rmode));
    // second device in phase: shared lines, opposite channel assign
    serial_dac_input dut_pair_u (.clock_i(clock_i), .rst_i(rst_i),
        .bit_clock_i(bclk), .serial_data_i(sdata),
        .word_latch_clock_i(latch), .channel_select_i(sel),
        .single_dac_mode_select_i(mode),
        .dac_channel_assign_i(!chan_assign), .dac_word_o(pair_dac),
        .left_out_o(), .right_out_o(), .left_parked_o(),
        .left_mode_o(), .right_mode_o());
    //////////////////////////////////////////////////////////////////
    task summarize;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : summarize
    task check(input string what, input logic [15:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one frame from the source, bounded wait for its end
    task send(input logic [15:0] w, input logic x);
        int n;
        word <= w;
        extra <= x;
        go <= 1'b1;
        @(posedge clock_i);
        go <= 1'b0;
        @(posedge clock_i);
        for (n = 0; n < 2000 && done !== 1'b1; n++) @(posedge clock_i);
        if (n == 2000) begin
            n_errors++;
            $display("wrong value done expected 1 seen 0");
            summarize();
        end
    endtask : send
    //////////////////////////////////////////////////////////////////
    task t_dual;
        sel <= 1'b1;
        send(FULL_POS_CODE, 1'b1);
        check("dac", dac, FULL_POS_CODE);
        sel <= 1'b0;
        send(FULL_NEG_CODE, 1'b1);
        check("dac", dac, FULL_NEG_CODE);
        check("left", lout, FULL_POS_CODE);
        sel <= 1'b1;
        send(BIPOLAR_ZERO_CODE, 1'b1);
        check("right", rout, FULL_NEG_CODE);
        check("dac", dac, BIPOLAR_ZERO_CODE);
        $display("test dual done");
    endtask : t_dual
    // stopped clock: transfer waits for the next frame's first rise
    task t_stop;
        sel <= 1'b0;
        send(16'h1234, 1'b0);
        check("dac", dac, BIPOLAR_ZERO_CODE);
        check("lmode", {14'h0, lmode}, {14'h0, MODE_INTEGRATE});
        check("rmode", {14'h0, rmode}, {14'h0, MODE_HOLD});
        sel <= 1'b1;
        send(16'habcd, 1'b1);
        check("right", rout, 16'h1234);
        check("dac", dac, 16'habcd);
        $display("test stop done");
    endtask : t_stop
    task t_single;
        mode <= 1'b1;
        sel <= 1'b0;
        send(16'h5555, 1'b1);
        check("dac", dac, 16'habcd);
        check("right", rout, 16'h1234);
        check("left", lout, COMMON_LEVEL_CODE);
        check("parked", {15'h0000, parked}, 16'h0001);
        check("lmode", {14'h0000, lmode}, {14'h0000, MODE_COMMON});
        check("rmode", {14'h0, rmode}, {14'h0, MODE_HOLD});
        check("pair dac", pair_dac, 16'h5555);
        sel <= 1'b1;
        send(16'h5555, 1'b1);
        check("dac", dac, 16'h5555);
        check("right", rout, 16'habcd);
        check("rmode", {14'h0, rmode}, {14'h0, MODE_INTEGRATE});
        check("pair dac", pair_dac, 16'h5555);
        chan_assign <= 1'b1;
        send(16'h6666, 1'b1);
        check("dac", dac, 16'h5555);
        check("pair dac", pair_dac, 16'h6666);
        sel <= 1'b0;
        send(16'h6666, 1'b1);
        check("dac", dac, 16'h6666);
        $display("test single done");
    endtask : t_single
    initial begin
        repeat (8) @(posedge clock_i);
        rst_i <= 1'b0;
        @(posedge clock_i);
        check("dac", dac, BIPOLAR_ZERO_CODE);
        t_dual();
        t_stop();
        t_single();
        summarize();
    end
endmodule : dual_channel_serial_dac_input_control_bench
